//--- src/ccp_capture_compare_unit.sv
// capture/compare channel top with apb register file
//
// Contract
// - remap config bit 1 selects default pin group, 0 the alternate group
// - capture copies full 16-bit selected timer count into data pair
// - capture on falling, rising, every 4th or every 16th rising edge
// - low four control bits select the mode and prescale
// - every capture sets flag bit 1; only software clears it
// - a new capture silently overwrites an unread captured value
// - with pin as output, port latch writes still cause captures
// - capture mode change may flag; software masks and clears afterwards
// - prescaler counter cleared when off or not capturing
// - switching prescale keeps count; first capture may be partial
// - compare mode continuously compares data pair with selected timer
// - match drives pin high, low, toggles, or leaves port latch
// - a compare match sets the channel flag
// - writing zero to control clears compare output latch only
// - mode 1010 match only sets flag, pin untouched
// - mode 1011 match raises the special event trigger
// - special event trigger clears the selected timer
// - this channel's trigger never starts a conversion
// - timer select field picks timer 1, 3, 5 or 7
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ccp_capture_compare_unit (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // configuration
  input wire logic i_pin_remap_config_bit,
  // timers
  input wire logic [15:0] i_tmr1_count,
  input wire logic [15:0] i_tmr3_count,
  input wire logic [15:0] i_tmr5_count,
  input wire logic [15:0] i_tmr7_count,
  output logic [3:0] o_tmr_clear,
  output logic o_special_event,
  output logic o_adc_start,
  // channel request
  output logic o_chan_irq,
  output logic o_chan_irq_high_prio,
  // pins
  input wire logic [1:0] i_pin_in,
  output logic [1:0] o_pin_out,
  output logic [1:0] o_pin_oe
);
  // ==========================================
  // registers
  logic [3:0] mode_r;
  logic [15:0] data_r;
  logic [1:0] tsel_r;
  logic [7:0] flags_r;
  logic [7:0] enables_r;
  logic [7:0] priority_r;
  logic dir_r;
  logic latch_r;
  logic cmp_latch_r;
  logic match_d_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [3:0] tmr_clear_r;
  logic special_r;
  logic irq_r;
  logic irq_hp_r;

  logic wr_en;
  logic rd_en;
  logic [15:0] tmr_sel;
  logic capture;
  logic level;
  logic is_compare;
  logic match;
  logic match_evt;
  logic drive_level;
  logic pin_by_cmp;
  logic addr_ok;

  // ==========================================
  // apb handshake: one wait state, answer registered
  assign wr_en = i_psel & i_penable & pready_r & i_pwrite;
  assign rd_en = i_psel & i_penable & ~pready_r & ~i_pwrite;
  assign addr_ok = (i_paddr == ccp_pkg::ADDR_CTRL) || (i_paddr == ccp_pkg::ADDR_DATA) ||
                   (i_paddr == ccp_pkg::ADDR_TSEL) || (i_paddr == ccp_pkg::ADDR_FLAGS) ||
                   (i_paddr == ccp_pkg::ADDR_ENABLES) || (i_paddr == ccp_pkg::ADDR_PRIORITY) ||
                   (i_paddr == ccp_pkg::ADDR_PORT);

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= i_psel & i_penable & ~pready_r;
      pslverr_r <= i_psel & i_penable & ~pready_r & ~addr_ok;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_en) begin
      if (i_paddr == ccp_pkg::ADDR_CTRL) begin
        prdata_r <= {28'h000_0000, mode_r};
      end else if (i_paddr == ccp_pkg::ADDR_DATA) begin
        prdata_r <= {16'h0000, data_r};
      end else if (i_paddr == ccp_pkg::ADDR_TSEL) begin
        prdata_r <= {30'h0000_0000, tsel_r};
      end else if (i_paddr == ccp_pkg::ADDR_FLAGS) begin
        prdata_r <= {24'h00_0000, flags_r};
      end else if (i_paddr == ccp_pkg::ADDR_ENABLES) begin
        prdata_r <= {24'h00_0000, enables_r};
      end else if (i_paddr == ccp_pkg::ADDR_PRIORITY) begin
        prdata_r <= {24'h00_0000, priority_r};
      end else if (i_paddr == ccp_pkg::ADDR_PORT) begin
        prdata_r <= {29'h0000_0000, level, latch_r, dir_r};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end else if (!(i_psel & i_penable)) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // ==========================================
  // control registers
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_r <= ccp_pkg::CTRL_RST;
    end else if (wr_en && i_paddr == ccp_pkg::ADDR_CTRL) begin
      mode_r <= i_pwdata[3:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tsel_r <= ccp_pkg::TSEL_RST;
    end else if (wr_en && i_paddr == ccp_pkg::ADDR_TSEL) begin
      tsel_r <= i_pwdata[1:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      enables_r <= ccp_pkg::ENABLES_RST;
      priority_r <= ccp_pkg::PRIORITY_RST;
    end else begin
      if (wr_en && i_paddr == ccp_pkg::ADDR_ENABLES) begin
        enables_r <= i_pwdata[7:0];
      end
      if (wr_en && i_paddr == ccp_pkg::ADDR_PRIORITY) begin
        priority_r <= i_pwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dir_r <= ccp_pkg::DIR_RST;
      latch_r <= ccp_pkg::LATCH_RST;
    end else if (wr_en && i_paddr == ccp_pkg::ADDR_PORT) begin
      dir_r <= i_pwdata[ccp_pkg::PORT_DIR_BIT];
      latch_r <= i_pwdata[ccp_pkg::PORT_LATCH_BIT];
    end
  end

  // ==========================================
  // timer selection
  always_comb begin
    case (tsel_r)
      ccp_pkg::TSEL_T1: tmr_sel = i_tmr1_count;
      ccp_pkg::TSEL_T3: tmr_sel = i_tmr3_count;
      ccp_pkg::TSEL_T5: tmr_sel = i_tmr5_count;
      default: tmr_sel = i_tmr7_count;
    endcase
  end

  // ==========================================
  // capture
  ccp_capt_presc u_capt (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_mode(mode_r),
    .i_level(level),
    .o_capture(capture)
  );

  // capture wins over a software write in the same cycle
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_r <= ccp_pkg::DATA_RST;
    end else if (capture) begin
      data_r <= tmr_sel;
    end else if (wr_en && i_paddr == ccp_pkg::ADDR_DATA) begin
      data_r <= i_pwdata[15:0];
    end
  end

  // ==========================================
  // compare
  assign is_compare = (mode_r == ccp_pkg::MODE_CMP_TOGGLE) || (mode_r[3:2] == 2'b10);
  assign match = is_compare && (data_r == tmr_sel);
  assign match_evt = match & ~match_d_r;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      match_d_r <= 1'b0;
    end else begin
      match_d_r <= match;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmp_latch_r <= 1'b0;
    end else if (wr_en && i_paddr == ccp_pkg::ADDR_CTRL && i_pwdata[7:0] == 8'h00) begin
      cmp_latch_r <= 1'b0;
    end else if (match_evt) begin
      case (mode_r)
        ccp_pkg::MODE_CMP_HIGH: cmp_latch_r <= 1'b1;
        ccp_pkg::MODE_CMP_LOW: cmp_latch_r <= 1'b0;
        ccp_pkg::MODE_CMP_TOGGLE: cmp_latch_r <= ~cmp_latch_r;
        default: cmp_latch_r <= cmp_latch_r;
      endcase
    end
  end

  // pin follows the port latch unless a driving compare mode owns it
  assign pin_by_cmp = (mode_r == ccp_pkg::MODE_CMP_HIGH) || (mode_r == ccp_pkg::MODE_CMP_LOW) ||
                      (mode_r == ccp_pkg::MODE_CMP_TOGGLE);
  assign drive_level = pin_by_cmp ? cmp_latch_r : latch_r;

  ccp_pin_ctl u_pin (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_pin_remap_config_bit(i_pin_remap_config_bit),
    .i_pin_direction_bit(dir_r),
    .i_drive_level(drive_level),
    .i_pin_in(i_pin_in),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe),
    .o_level(level)
  );

  // ==========================================
  // special event trigger
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      special_r <= 1'b0;
      tmr_clear_r <= 4'h0;
    end else begin
      special_r <= match_evt && (mode_r == ccp_pkg::MODE_CMP_SPEC);
      for (int t = 0; t < ccp_pkg::NUM_TIMERS; t++) begin
        tmr_clear_r[t] <= match_evt && (mode_r == ccp_pkg::MODE_CMP_SPEC) && (tsel_r == 2'(t));
      end
    end
  end

  // ==========================================
  // flags: hardware set wins over software clear
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_r <= ccp_pkg::FLAGS_RST;
    end else begin
      if (wr_en && i_paddr == ccp_pkg::ADDR_FLAGS) begin
        flags_r <= i_pwdata[7:0];
      end
      if (capture || match_evt) begin
        flags_r[ccp_pkg::FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_r <= 1'b0;
      irq_hp_r <= 1'b0;
    end else begin
      irq_r <= flags_r[ccp_pkg::FLAG_BIT] & enables_r[ccp_pkg::FLAG_BIT];
      irq_hp_r <= flags_r[ccp_pkg::FLAG_BIT] & enables_r[ccp_pkg::FLAG_BIT] & priority_r[ccp_pkg::FLAG_BIT];
    end
  end

  // ==========================================
  // outputs
  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_tmr_clear = tmr_clear_r;
  assign o_special_event = special_r;
  assign o_chan_irq = irq_r;
  assign o_chan_irq_high_prio = irq_hp_r;

  // conversion start held low from a constant flop
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_adc_start <= 1'b0;
    end else begin
      o_adc_start <= 1'b0;
    end
  end
endmodule : ccp_capture_compare_unit
`default_nettype wire

//--- shared/ccp_pkg.sv
// package with register map, mode codes and field positions of the capture/compare channel
package ccp_pkg;
  // ==========================================
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_TSEL = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_ENABLES = 8'h10;
  localparam logic [7:0] ADDR_PRIORITY = 8'h14;
  localparam logic [7:0] ADDR_PORT = 8'h18;
  // ==========================================
  // field positions
  localparam int FLAG_BIT = 1;
  localparam int PORT_DIR_BIT = 0;
  localparam int PORT_LATCH_BIT = 1;
  localparam int PORT_LEVEL_BIT = 2;
  // ==========================================
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [1:0] TSEL_RST = 2'h0;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [7:0] PRIORITY_RST = 8'h00;
  localparam logic DIR_RST = 1'b1;
  localparam logic LATCH_RST = 1'b0;
  // ==========================================
  // mode field codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_HIGH = 4'h8;
  localparam logic [3:0] MODE_CMP_LOW = 4'h9;
  localparam logic [3:0] MODE_CMP_SWINT = 4'hA;
  localparam logic [3:0] MODE_CMP_SPEC = 4'hB;
  // ==========================================
  // prescale terminal counts
  localparam logic [3:0] PRESC_LAST4 = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hF;
  // ==========================================
  // timer select codes
  localparam logic [1:0] TSEL_T1 = 2'h0;
  localparam logic [1:0] TSEL_T3 = 2'h1;
  localparam logic [1:0] TSEL_T5 = 2'h2;
  localparam logic [1:0] TSEL_T7 = 2'h3;
  localparam int NUM_TIMERS = 4;
  localparam int NUM_PIN_GROUPS = 2;
endpackage : ccp_pkg

//--- src/ccp_capt_presc.sv
// capture edge detect and prescaler
`timescale 1ns/10ps
`default_nettype none
module ccp_capt_presc (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // control
  input wire logic [3:0] i_mode,
  input wire logic i_level,
  // event
  output logic o_capture
);
  logic level_d_r;
  logic [3:0] cnt_r;
  logic is_capture;
  logic rise;
  logic fall;

  assign is_capture = (i_mode == ccp_pkg::MODE_CAP_FALL) || (i_mode == ccp_pkg::MODE_CAP_RISE) ||
                      (i_mode == ccp_pkg::MODE_CAP_RISE4) || (i_mode == ccp_pkg::MODE_CAP_RISE16);
  assign rise = i_level & ~level_d_r;
  assign fall = ~i_level & level_d_r;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level_d_r <= 1'b0;
    end else begin
      level_d_r <= i_level;
    end
  end

  // count kept across prescale changes, cleared outside capture
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= 4'h0;
    end else if (!is_capture) begin
      cnt_r <= 4'h0;
    end else if (rise) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  always_comb begin
    o_capture = 1'b0;
    case (i_mode)
      ccp_pkg::MODE_CAP_FALL: o_capture = fall;
      ccp_pkg::MODE_CAP_RISE: o_capture = rise;
      ccp_pkg::MODE_CAP_RISE4: o_capture = rise && (cnt_r[1:0] == ccp_pkg::PRESC_LAST4[1:0]);
      ccp_pkg::MODE_CAP_RISE16: o_capture = rise && (cnt_r == ccp_pkg::PRESC_LAST16);
      default: o_capture = 1'b0;
    endcase
  end
endmodule : ccp_capt_presc
`default_nettype wire

//--- src/ccp_pin_ctl.sv
// pin group multiplexing, drive and effective pin level
`timescale 1ns/10ps
`default_nettype none
module ccp_pin_ctl (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // control
  input wire logic i_pin_remap_config_bit,
  input wire logic i_pin_direction_bit,
  input wire logic i_drive_level,
  // pins, group 0 default, group 1 alternate
  input wire logic [1:0] i_pin_in,
  output logic [1:0] o_pin_out,
  output logic [1:0] o_pin_oe,
  // level seen by capture logic
  output logic o_level
);
  logic [1:0] grp_sel;

  // remap 1 picks group 0, remap 0 picks group 1
  assign grp_sel = i_pin_remap_config_bit ? 2'b01 : 2'b10;

  genvar g;
  generate
    for (g = 0; g < ccp_pkg::NUM_PIN_GROUPS; g++) begin : g_grp
      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          o_pin_out[g] <= 1'b0;
          o_pin_oe[g] <= 1'b0;
        end else begin
          o_pin_out[g] <= grp_sel[g] & i_drive_level;
          o_pin_oe[g] <= grp_sel[g] & ~i_pin_direction_bit;
        end
      end
    end
  endgenerate

  // an output pin reads back its own drive, so port writes can capture
  always_comb begin
    if (!i_pin_direction_bit) begin
      o_level = i_drive_level;
    end else begin
      o_level = i_pin_remap_config_bit ? i_pin_in[0] : i_pin_in[1];
    end
  end
endmodule : ccp_pin_ctl
`default_nettype wire

//--- tb/ccp_capture_compare_unit_props.sv
// assertion checker for the capture/compare channel ports
`timescale 1ns/10ps
`default_nettype none
module ccp_capture_compare_unit_props (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // channel
  input wire logic i_pin_remap_config_bit,
  input wire logic [15:0] i_tmr1_count,
  input wire logic [15:0] i_tmr3_count,
  input wire logic [15:0] i_tmr5_count,
  input wire logic [15:0] i_tmr7_count,
  input wire logic [3:0] o_tmr_clear,
  input wire logic o_special_event,
  input wire logic o_adc_start,
  input wire logic o_chan_irq,
  input wire logic o_chan_irq_high_prio,
  input wire logic [1:0] i_pin_in,
  input wire logic [1:0] o_pin_out,
  input wire logic [1:0] o_pin_oe
);
  // ==========================================
  // shadow of the written registers
  logic [3:0] mode_r;
  logic [1:0] tsel_r;
  logic [15:0] data_r;
  logic en_r;
  logic [15:0] sel_cnt;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_r <= 4'h0;
      tsel_r <= 2'h0;
      data_r <= 16'h0000;
      en_r <= 1'b0;
    end else if (i_psel && i_penable && i_pwrite && o_pready) begin
      if (i_paddr == ccp_pkg::ADDR_CTRL) mode_r <= i_pwdata[3:0];
      if (i_paddr == ccp_pkg::ADDR_TSEL) tsel_r <= i_pwdata[1:0];
      if (i_paddr == ccp_pkg::ADDR_DATA) data_r <= i_pwdata[15:0];
      if (i_paddr == ccp_pkg::ADDR_ENABLES) en_r <= i_pwdata[1];
    end
  end
  always_comb begin
    case (tsel_r)
      2'h0: sel_cnt = i_tmr1_count;
      2'h1: sel_cnt = i_tmr3_count;
      2'h2: sel_cnt = i_tmr5_count;
      default: sel_cnt = i_tmr7_count;
    endcase
  end
  // ==========================================
  // properties
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  adc_quiet_a: assert property (o_adc_start == 1'b0)
    else $error("conversion start raised");
  special_mode_a: assert property (o_special_event |-> $past(mode_r) == ccp_pkg::MODE_CMP_SPEC)
    else $error("trigger outside its mode");
  special_match_a: assert property (o_special_event |-> $past(sel_cnt) == $past(data_r))
    else $error("trigger without a match");
  clear_select_a: assert property (o_special_event |-> o_tmr_clear == (4'h1 << $past(tsel_r)))
    else $error("wrong timer cleared");
  clear_cause_a: assert property (o_tmr_clear != 4'h0 |-> o_special_event)
    else $error("timer clear without trigger");
  special_pulse_a: assert property (o_special_event |=> !o_special_event)
    else $error("trigger longer than a cycle");
  idle_group_a: assert property ($stable(i_pin_remap_config_bit) |-> !o_pin_oe[i_pin_remap_config_bit])
    else $error("unselected pin group driven");
  irq_enable_a: assert property (o_chan_irq |-> $past(en_r))
    else $error("request while masked");
  cover property (o_special_event);
  cover property (o_chan_irq_high_prio);
  cover property (o_pslverr);
endmodule : ccp_capture_compare_unit_props
bind ccp_capture_compare_unit ccp_capture_compare_unit_props i_ccp_capture_compare_unit_props (.*);
`default_nettype wire

//--- tb/ccp_far_model.sv
// far-side model: four timers and the pin source
`timescale 1ns/10ps
`default_nettype none
module ccp_far_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // stimulus
  input wire logic i_run,
  input wire logic i_src_level,
  input wire logic i_remap,
  // from the channel
  input wire logic [3:0] i_tmr_clear,
  input wire logic [1:0] i_pin_out,
  input wire logic [1:0] i_pin_oe,
  // to the channel
  output logic [3:0][15:0] o_cnt,
  output logic [1:0] o_pin_in
);
  // ==========================================
  // timers counted on the core clock
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < 4; k++) o_cnt[k] <= 16'h1111 * 16'(k + 1);
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (i_tmr_clear[k]) o_cnt[k] <= 16'h0000;
        else if (i_run) o_cnt[k] <= o_cnt[k] + 16'h0001;
      end
    end
  end
  // ==========================================
  // pins: driven level wins, idle group sees the inverse
  for (genvar g = 0; g < 2; g++) begin : g_pin
    assign o_pin_in[g] = i_pin_oe[g] ? i_pin_out[g] : (((g == 0) == i_remap) ? i_src_level : !i_src_level);
  end
endmodule : ccp_far_model
`default_nettype wire

//--- tb/tb_ccp_capture_compare_unit.sv
// self-checking testbench of the capture/compare channel
`timescale 1ns/10ps
`default_nettype none
module tb_ccp_capture_compare_unit;
  // ==========================================
  // signals
  logic clk, rst_n, psel, penable, pwrite, remap, run, src, pready, pslverr, err, irq, irq_hp, spec, adc;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] tclr, m;
  logic [3:0][15:0] tcnt;
  logic [1:0] pin_in, pin_out, pin_oe, t;
  logic [15:0] exp_t;
  logic [3:0] modes [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
  logic [4:0] pins = 5'h05;
  int n_fail, n_checks, seed, n, np;
  ccp_capture_compare_unit i_ccp_capture_compare_unit (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pin_remap_config_bit(remap), .i_tmr1_count(tcnt[0]), .i_tmr3_count(tcnt[1]),
    .i_tmr5_count(tcnt[2]), .i_tmr7_count(tcnt[3]), .o_tmr_clear(tclr), .o_special_event(spec),
    .o_adc_start(adc), .o_chan_irq(irq), .o_chan_irq_high_prio(irq_hp), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe));
  ccp_far_model i_ccp_far_model (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_run(run), .i_src_level(src), .i_remap(remap),
    .i_tmr_clear(tclr), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_cnt(tcnt), .o_pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================
  // tasks
  task automatic print_verdict();
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      print_verdict();
    end
    @(posedge clk);
  endtask : apb
  task automatic pulse();
    src <= 1'b1;
    cyc(3);
    src <= 1'b0;
    cyc(3);
  endtask : pulse
  // ==========================================
  // main sequence
  initial begin
    seed = 32'h682AF65D;
    n_fail = 0;
    n_checks = 0;
    {rst_n, psel, penable, pwrite, run, src, paddr, pwdata, remap} = '0;
    cyc(4);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, ccp_pkg::ADDR_PORT, 32'h0);
    chk("port reset", 32'h1, rd & 32'h3);
    apb(1'b1, 8'h1C, 32'hFFFFFFFF);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      m = ccp_pkg::MODE_CAP_FALL + 4'(i);
      np = (i == 2) ? 4 : (i == 3) ? 16 : 1;
      t = 2'($random(seed));
      remap <= 1'($random(seed));
      apb(1'b1, ccp_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, ccp_pkg::ADDR_TSEL, 32'(t));
      apb(1'b1, ccp_pkg::ADDR_FLAGS, 32'h0);
      pulse();
      apb(1'b0, ccp_pkg::ADDR_FLAGS, 32'h0);
      chk("flag while off", 32'h0, rd);
      apb(1'b1, ccp_pkg::ADDR_CTRL, 32'(m));
      apb(1'b1, ccp_pkg::ADDR_FLAGS, 32'h0);
      for (int r = 0; r < 2; r++) begin
        apb(1'b1, ccp_pkg::ADDR_FLAGS, 32'h0);
        run <= 1'b1;
        cyc(2 + ($random(seed) & 63));
        run <= 1'b0;
        cyc(1);
        exp_t = tcnt[t];
        repeat (np - 1) pulse();
        apb(1'b0, ccp_pkg::ADDR_FLAGS, 32'h0);
        chk("flag before last edge", 32'h0, rd);
        pulse();
        apb(1'b0, ccp_pkg::ADDR_FLAGS, 32'h0);
        chk("capture flag", 32'h2, rd);
        apb(1'b0, ccp_pkg::ADDR_DATA, 32'h0);
        chk("captured count", 32'(exp_t), rd);
      end
    end
    apb(1'b1, ccp_pkg::ADDR_CTRL, 32'(ccp_pkg::MODE_CAP_RISE));
    apb(1'b1, ccp_pkg::ADDR_PORT, 32'h0);
    apb(1'b1, ccp_pkg::ADDR_FLAGS, 32'h0);
    exp_t = tcnt[t];
    apb(1'b1, ccp_pkg::ADDR_PORT, 32'h2);
    apb(1'b0, ccp_pkg::ADDR_DATA, 32'h0);
    chk("capture by port write", 32'(exp_t), rd);
    chk("driven group", 32'(remap ? 2'h1 : 2'h2), 32'(pin_oe));
    apb(1'b1, ccp_pkg::ADDR_ENABLES, 32'h2);
    apb(1'b1, ccp_pkg::ADDR_PRIORITY, 32'h2);
    apb(1'b1, ccp_pkg::ADDR_PORT, 32'h0);
    apb(1'b1, ccp_pkg::ADDR_CTRL, 32'h0);
    run <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      t = 2'($random(seed));
      apb(1'b1, ccp_pkg::ADDR_TSEL, 32'(t));
      apb(1'b1, ccp_pkg::ADDR_DATA, 32'(tcnt[t] + 16'h0040));
      apb(1'b1, ccp_pkg::ADDR_CTRL, 32'(modes[i]));
      apb(1'b1, ccp_pkg::ADDR_FLAGS, 32'h0);
      cyc(2);
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      if (n >= 300) begin
        n_fail++;
        print_verdict();
      end
      cyc(3);
      chk("compare pin", 32'(pins[i]), 32'(pin_out[!remap]));
      chk("high priority request", 32'h1, 32'(irq_hp));
      if (i == 4) chk("cleared timer", 32'h1, 32'(tcnt[t] < 16'h0010));
    end
    run <= 1'b0;
    apb(1'b1, ccp_pkg::ADDR_PORT, 32'h2);
    apb(1'b1, ccp_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, ccp_pkg::ADDR_CTRL, 32'(ccp_pkg::MODE_CMP_TOGGLE));
    cyc(2);
    chk("compare latch cleared", 32'h0, 32'(pin_out[!remap]));
    apb(1'b0, ccp_pkg::ADDR_PORT, 32'h0);
    chk("port latch kept", 32'h2, rd & 32'h3);
    // ==========================================
    // reset in mid-run clears a partial prescale count
    apb(1'b1, ccp_pkg::ADDR_PORT, 32'h1);
    apb(1'b1, ccp_pkg::ADDR_CTRL, 32'(ccp_pkg::MODE_CAP_RISE4));
    repeat (2) pulse();
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    apb(1'b0, ccp_pkg::ADDR_PORT, 32'h0);
    chk("port after reset", 32'h1, rd & 32'h3);
    apb(1'b1, ccp_pkg::ADDR_CTRL, 32'(ccp_pkg::MODE_CAP_RISE4));
    repeat (3) pulse();
    apb(1'b0, ccp_pkg::ADDR_FLAGS, 32'h0);
    chk("prescaler after reset", 32'h0, rd);
    pulse();
    apb(1'b0, ccp_pkg::ADDR_FLAGS, 32'h0);
    chk("capture after reset", 32'h2, rd);
    print_verdict();
  end
endmodule : tb_ccp_capture_compare_unit
`default_nettype wire
